// File: verilog/hsc_cfg.svh
`ifndef HSC_CFG_SVH
`define HSC_CFG_SVH
`define HSC_PORTS 4
`define HSC_SYNC_W 9
`define HSC_ADDR_W 8
`define HSC_DATA_W 32
`define HSC_ADDR_CTRL 8'h00
`define HSC_ADDR_STRAP 8'h04
`define HSC_CTRL_STS_EN 0
`define HSC_STRAP_W 7
`define HSC_S_PSW 0
`define HSC_S_POL 1
`define HSC_S_GANG 2
`define HSC_S_AUTO 3
`define HSC_S_SIDE 4
`define HSC_S_ADDR1 5
`define HSC_S_ADDR2 6
`define HSC_STRAP_VALID 7
`define HSC_STRAP_RST 7'h00
`define HSC_CNT_W 2
`define HSC_SETTLE_CYCLES 2'h2
`define HSC_MODES_ALL 3'h7
`define HSC_MODES_TOP 3'h4
`define HSC_MODES_W 3
`define HSC_Y_SIDE 0
`define HSC_Y_PSW 1
`define HSC_Y_POL 2
`define HSC_Y_GANG 3
`define HSC_Y_AUTO 4
`define HSC_Y_OC 5
`endif

// File: verilog/hsc_pkg.sv
package hsc_pkg;
  typedef enum logic [1:0] {
    HSC_ST_SETTLE = 2'b01,
    HSC_ST_RUN = 2'b10
  } hsc_state_t;
  typedef logic [3:0] hsc_port_mask_t;
endpackage : hsc_pkg

// File: verilog/hsc_sync.sv
module hsc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r[i] <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          meta_r[i] <= d[i];
          q[i] <= meta_r[i];
        end
      end
    end
  endgenerate
endmodule : hsc_sync

// File: verilog/hsc_strap_loader.sv
// Chosen here: the register addresses and the plain strobed port.
`include "hsc_cfg.svh"
module hsc_strap_loader (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`HSC_ADDR_W-1:0] reg_addr,
  input wire logic [`HSC_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`HSC_DATA_W-1:0] reg_rdata,
  input wire logic psw_pin_in,
  output logic psw_pin_out,
  output logic psw_pin_oe,
  input wire logic gang_pin_in,
  output logic gang_pin_out,
  output logic gang_pin_oe,
  input wire logic polarity_pin_in,
  input wire logic auto_pin_in,
  input wire logic sideband_pin_in,
  input wire logic [`HSC_PORTS-1:0] overcurrent_n_pin,
  input wire logic upstream_superspeed_linked,
  input wire logic upstream_highspeed_linked,
  input wire logic upstream_connected,
  input wire logic [`HSC_PORTS-1:0] port_power_request,
  input wire logic [`HSC_PORTS-1:0] port_charging_enable,
  output logic [`HSC_PORTS-1:0] port_power_switch_out,
  output logic [`HSC_PORTS-1:0] overcurrent_event,
  output logic straps_valid,
  output logic power_switching_disable_strap,
  output logic top_current_only_flag,
  output logic switch_output_polarity,
  output logic ganged_mode,
  output logic auto_charge_disable_strap,
  output logic sideband_interface_select,
  output logic slave_addr_bit_one_strap,
  output logic slave_addr_bit_two_strap,
  output logic [`HSC_MODES_W-1:0] divider_charging_mode,
  output logic [`HSC_PORTS-1:0] auto_mode_port
);

  // pin synchronisers
  logic [`HSC_SYNC_W-1:0] pin_raw;
  logic [`HSC_SYNC_W-1:0] pin_sync;

  assign pin_raw = {overcurrent_n_pin, auto_pin_in, gang_pin_in,
                    polarity_pin_in, psw_pin_in, sideband_pin_in};

  hsc_sync #(
    .W(`HSC_SYNC_W)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(pin_raw),
    .q(pin_sync)
  );

  wire logic [`HSC_PORTS-1:0] oc_n_sync;
  assign oc_n_sync = pin_sync[`HSC_SYNC_W-1:`HSC_Y_OC];

  // capture sequencer
  hsc_pkg::hsc_state_t state_r;
  hsc_pkg::hsc_state_t state_nxt;
  logic [`HSC_CNT_W-1:0] cnt_r;
  logic [`HSC_CNT_W-1:0] cnt_nxt;
  wire logic settle_done;
  wire logic capture;

  assign settle_done = (cnt_r == `HSC_SETTLE_CYCLES);
  assign capture = (state_r == hsc_pkg::HSC_ST_SETTLE) && settle_done;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      hsc_pkg::HSC_ST_SETTLE: begin
        if (settle_done) begin
          state_nxt = hsc_pkg::HSC_ST_RUN;
        end else begin
          cnt_nxt = cnt_r + 2'h1;
        end
      end
      hsc_pkg::HSC_ST_RUN: begin
        state_nxt = hsc_pkg::HSC_ST_RUN;
      end
      default: begin
        state_nxt = hsc_pkg::HSC_ST_SETTLE;
        cnt_nxt = 2'h0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= hsc_pkg::HSC_ST_SETTLE;
      cnt_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // strap capture
  logic [`HSC_STRAP_W-1:0] strap_r;
  logic [`HSC_STRAP_W-1:0] strap_nxt;
  logic valid_r;
  wire logic [`HSC_STRAP_W-1:0] strap_sample;

  assign strap_sample[`HSC_S_PSW] = pin_sync[`HSC_Y_PSW];
  assign strap_sample[`HSC_S_POL] = pin_sync[`HSC_Y_POL];
  assign strap_sample[`HSC_S_GANG] = pin_sync[`HSC_Y_GANG];
  assign strap_sample[`HSC_S_AUTO] = pin_sync[`HSC_Y_AUTO];
  assign strap_sample[`HSC_S_SIDE] = pin_sync[`HSC_Y_SIDE];
  assign strap_sample[`HSC_S_ADDR1] = pin_sync[`HSC_Y_PSW];
  assign strap_sample[`HSC_S_ADDR2] = pin_sync[`HSC_Y_GANG];
  assign strap_nxt = capture ? strap_sample : strap_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_r <= `HSC_STRAP_RST;
      valid_r <= 1'b0;
    end else begin
      strap_r <= strap_nxt;
      valid_r <= valid_r | capture;
    end
  end

  wire logic psw_dis;
  wire logic pol_high;
  wire logic gang;
  wire logic auto_en;
  wire logic smbus_mode;

  assign psw_dis = strap_r[`HSC_S_PSW];
  assign pol_high = strap_r[`HSC_S_POL];
  assign gang = strap_r[`HSC_S_GANG];
  assign auto_en = valid_r && !strap_r[`HSC_S_AUTO];
  assign smbus_mode = valid_r && !strap_r[`HSC_S_SIDE];

  assign straps_valid = valid_r;
  assign power_switching_disable_strap = psw_dis;
  assign top_current_only_flag = strap_r[`HSC_S_PSW];
  assign switch_output_polarity = pol_high;
  assign ganged_mode = gang;
  assign auto_charge_disable_strap = strap_r[`HSC_S_AUTO];
  assign sideband_interface_select = strap_r[`HSC_S_SIDE];
  assign slave_addr_bit_one_strap = smbus_mode && strap_r[`HSC_S_ADDR1];
  assign slave_addr_bit_two_strap = smbus_mode && strap_r[`HSC_S_ADDR2];

  // charging modes
  wire logic [`HSC_MODES_W-1:0] modes_nxt;
  wire hsc_pkg::hsc_port_mask_t auto_port_nxt;
  logic [`HSC_MODES_W-1:0] modes_r;
  hsc_pkg::hsc_port_mask_t auto_port_r;

  assign modes_nxt = (auto_en && top_current_only_flag) ? `HSC_MODES_TOP
                                                        : `HSC_MODES_ALL;
  assign auto_port_nxt = (auto_en && !upstream_connected) ? port_charging_enable
                                                          : 4'h0;

  // power switches and over-current
  wire hsc_pkg::hsc_port_mask_t sw_on;
  wire hsc_pkg::hsc_port_mask_t sw_nxt;
  wire hsc_pkg::hsc_port_mask_t oc_act;
  wire hsc_pkg::hsc_port_mask_t oc_nxt;
  logic [`HSC_PORTS-1:0] sw_r;
  logic [`HSC_PORTS-1:0] oc_r;

  assign sw_on = (!valid_r || psw_dis) ? 4'h0
               : gang ? {`HSC_PORTS{|port_power_request}}
               : port_power_request;
  assign sw_nxt = pol_high ? sw_on : ~sw_on;
  assign oc_act = ~oc_n_sync;
  assign oc_nxt = (!valid_r || psw_dis) ? 4'h0
                : gang ? {`HSC_PORTS{|oc_act}}
                : oc_act;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_r <= 4'h0;
      oc_r <= 4'h0;
      modes_r <= `HSC_MODES_ALL;
      auto_port_r <= 4'h0;
    end else begin
      sw_r <= sw_nxt;
      oc_r <= oc_nxt;
      modes_r <= modes_nxt;
      auto_port_r <= auto_port_nxt;
    end
  end

  assign port_power_switch_out = sw_r;
  assign overcurrent_event = oc_r;
  assign divider_charging_mode = modes_r;
  assign auto_mode_port = auto_port_r;

  // register port
  logic sts_en_r;
  logic ss_out_r;
  logic hs_out_r;
  logic [`HSC_DATA_W-1:0] rdata_r;
  wire logic hit_ctrl;
  wire logic hit_strap;
  wire logic [`HSC_DATA_W-1:0] rd_mux;
  wire logic sts_drive;

  assign hit_ctrl = (reg_addr == `HSC_ADDR_CTRL);
  assign hit_strap = (reg_addr == `HSC_ADDR_STRAP);
  assign rd_mux = hit_ctrl ? {31'h0, sts_en_r}
                : hit_strap ? {24'h0, valid_r, strap_r}
                : 32'h0;
  assign sts_drive = valid_r && sts_en_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sts_en_r <= 1'b0;
      rdata_r <= 32'h0;
      ss_out_r <= 1'b0;
      hs_out_r <= 1'b0;
    end else begin
      if (reg_wr && hit_ctrl) begin
        sts_en_r <= reg_wdata[`HSC_CTRL_STS_EN];
      end
      rdata_r <= reg_rd ? rd_mux : 32'h0;
      ss_out_r <= upstream_superspeed_linked;
      hs_out_r <= upstream_highspeed_linked;
    end
  end

  assign reg_rdata = rdata_r;
  assign psw_pin_out = ss_out_r;
  assign psw_pin_oe = sts_drive;
  assign gang_pin_out = hs_out_r;
  assign gang_pin_oe = sts_drive;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_held;
    valid_r ##1 valid_r;
  endsequence

  sequence s_settle;
    !valid_r ##1 !valid_r ##1 !valid_r ##1 !valid_r;
  endsequence

  property p_capture_once;
    s_held |-> $stable(strap_r);
  endproperty

  a_straps_held_stable: assert property (p_capture_once)
    else $error("strap value changed after capture");

  a_capture_after_release: assert property (
    $rose(valid_r) |-> strap_r[`HSC_S_PSW] == $past(pin_sync[`HSC_Y_PSW])
      && strap_r[`HSC_S_GANG] == $past(pin_sync[`HSC_Y_GANG]))
    else $error("captured strap does not match sampled pin");

  a_settle_length: assert property (
    s_settle |=> valid_r)
    else $error("strap capture late after release");

  a_switch_off_dis: assert property (
    valid_r && psw_dis |=> port_power_switch_out == (pol_high ? 4'h0 : 4'hf))
    else $error("power switch driven while switching disabled");

  a_oc_ignored: assert property (
    valid_r && psw_dis |=> overcurrent_event == 4'h0)
    else $error("over-current reported while switching disabled");

  a_oc_individual: assert property (
    valid_r && !psw_dis && !gang |=> overcurrent_event == ~$past(oc_n_sync))
    else $error("over-current not forwarded per port");

  a_switch_individual: assert property (
    valid_r && !psw_dis && !gang && pol_high
      |=> port_power_switch_out == $past(port_power_request))
    else $error("per-port switch does not follow request");

  a_switch_polarity: assert property (
    valid_r && !psw_dis && !gang && !pol_high
      |=> port_power_switch_out == ~$past(port_power_request))
    else $error("active low switch output wrong");

  a_switch_ganged: assert property (
    valid_r && !psw_dis && gang && pol_high && |port_power_request
      |=> port_power_switch_out == 4'hf)
    else $error("ganged switches not all on");

  a_modes_top: assert property (
    auto_en && top_current_only_flag |=> divider_charging_mode == `HSC_MODES_TOP)
    else $error("top-current-only mode not applied");

  a_modes_all: assert property (
    auto_en && !top_current_only_flag |=> divider_charging_mode == `HSC_MODES_ALL)
    else $error("all divider modes not allowed");

  a_addr_bits: assert property (
    smbus_mode |-> slave_addr_bit_one_strap == strap_r[`HSC_S_PSW]
      && slave_addr_bit_two_strap == strap_r[`HSC_S_GANG])
    else $error("slave address bits do not follow straps");

  a_addr_master: assert property (
    valid_r && strap_r[`HSC_S_SIDE] |-> !slave_addr_bit_one_strap
      && !slave_addr_bit_two_strap)
    else $error("address bits shown in master mode");

  a_ss_status: assert property (
    sts_drive && upstream_superspeed_linked ##1 sts_drive |-> psw_pin_oe && psw_pin_out)
    else $error("superspeed status not driven");

  a_hs_status: assert property (
    sts_drive && upstream_highspeed_linked ##1 sts_drive |-> gang_pin_oe && gang_pin_out)
    else $error("high-speed status not driven");

  a_no_drive_early: assert property (
    !valid_r |-> !psw_pin_oe && !gang_pin_oe)
    else $error("strap pin driven before capture");

  a_auto_ports: assert property (
    auto_en && !upstream_connected |=> auto_mode_port == $past(port_charging_enable))
    else $error("auto mode not on charging ports");

  a_auto_off: assert property (
    valid_r && strap_r[`HSC_S_AUTO] |=> auto_mode_port == 4'h0)
    else $error("auto mode active while disabled");

  a_read_one_cycle: assert property (
    !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data present without read");

endmodule : hsc_strap_loader

// File: bench/hsc_board_model.sv
module hsc_board_model (
  input wire logic [4:0] strap,
  input wire logic psw_pin_out,
  input wire logic psw_pin_oe,
  input wire logic gang_pin_out,
  input wire logic gang_pin_oe,
  input wire logic [3:0] fault,
  output logic psw_pin_in,
  output logic gang_pin_in,
  output logic polarity_pin_in,
  output logic auto_pin_in,
  output logic sideband_pin_in,
  output logic [3:0] overcurrent_n_pin,
  output logic [3:0] port_charging_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  // strap resistors set a shared pin only while the device leaves it undriven
  assign psw_pin_in = psw_pin_oe ? psw_pin_out : strap[0];
  assign gang_pin_in = gang_pin_oe ? gang_pin_out : strap[2];
  assign polarity_pin_in = strap[1];
  assign auto_pin_in = strap[3];
  assign sideband_pin_in = strap[4];
  // switch flags an over-current as a low level
  assign overcurrent_n_pin = ~fault;
  // charging only with switching on and individual control
  assign port_charging_enable = (strap[0] | strap[2]) ? 4'h0 : 4'h9;
endmodule : hsc_board_model

// File: bench/tb_top.sv
`include "hsc_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [4:0] strap;
    logic [3:0] req;
    logic [3:0] sw;
    logic [2:0] modes;
  } hsc_row_t;
  logic clk, rst_n, reg_wr, reg_rd, straps_valid;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic psw_pin_in, psw_pin_out, psw_pin_oe, gang_pin_in, gang_pin_out, gang_pin_oe;
  logic polarity_pin_in, auto_pin_in, sideband_pin_in, upstream_connected;
  logic upstream_superspeed_linked, upstream_highspeed_linked;
  logic [3:0] overcurrent_n_pin, port_power_request, port_charging_enable, fault;
  logic [3:0] port_power_switch_out, overcurrent_event, auto_mode_port;
  logic power_switching_disable_strap, top_current_only_flag, switch_output_polarity;
  logic ganged_mode, auto_charge_disable_strap, sideband_interface_select;
  logic slave_addr_bit_one_strap, slave_addr_bit_two_strap;
  logic [2:0] divider_charging_mode;
  logic [4:0] strap;
  hsc_row_t r;
  int mismatches, checks_done;
  hsc_row_t rows [6] = '{'{5'h02, 4'h5, 4'h5, 3'h7}, '{5'h10, 4'h5, 4'ha, 3'h7},
    '{5'h0e, 4'h2, 4'hf, 3'h7}, '{5'h03, 4'hf, 4'h0, 3'h4},
    '{5'h1d, 4'hf, 4'hf, 3'h7}, '{5'h14, 4'h0, 4'hf, 3'h7}};

  hsc_strap_loader uut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .psw_pin_in, .psw_pin_out, .psw_pin_oe, .gang_pin_in, .gang_pin_out, .gang_pin_oe,
    .polarity_pin_in, .auto_pin_in, .sideband_pin_in, .overcurrent_n_pin,
    .upstream_superspeed_linked, .upstream_highspeed_linked, .upstream_connected,
    .port_power_request, .port_charging_enable, .port_power_switch_out, .overcurrent_event,
    .straps_valid, .power_switching_disable_strap, .top_current_only_flag,
    .switch_output_polarity, .ganged_mode, .auto_charge_disable_strap,
    .sideband_interface_select, .slave_addr_bit_one_strap, .slave_addr_bit_two_strap,
    .divider_charging_mode, .auto_mode_port);

  hsc_board_model board (.strap, .psw_pin_out, .psw_pin_oe, .gang_pin_out, .gang_pin_oe,
    .fault, .psw_pin_in, .gang_pin_in, .polarity_pin_in, .auto_pin_in, .sideband_pin_in,
    .overcurrent_n_pin, .port_charging_enable);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task summarize;
    if (mismatches == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(nm, exp, reg_rdata);
    @(posedge clk);
  endtask : rchk

  task do_reset(input logic [4:0] s);
    rst_n <= 1'b0;
    strap <= s;
    repeat (12) @(posedge clk);
    #1 chk("in_reset", 32'h0e0, {straps_valid, divider_charging_mode, psw_pin_oe,
      port_power_switch_out});
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("valid_early", 32'h0, straps_valid);
    @(posedge clk);
    #1 chk("valid", 32'h1, straps_valid);
    @(posedge clk);
  endtask : do_reset

  initial begin
    mismatches = 0;
    checks_done = 0;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    strap = 5'h00;
    fault = 4'h0;
    port_power_request = 4'h0;
    upstream_connected = 1'b0;
    upstream_superspeed_linked = 1'b0;
    upstream_highspeed_linked = 1'b0;
    for (int i = 0; i < 6; i++) begin
      r = rows[i];
      do_reset(r.strap);
      rchk("straps", `HSC_ADDR_STRAP, {24'h0, 1'b1, r.strap[2], r.strap[0], r.strap});
      chk("strap_outs", {r.strap[0], r.strap[0], r.strap[1], r.strap[2], r.strap[3],
        r.strap[4]}, {power_switching_disable_strap, top_current_only_flag,
        switch_output_polarity, ganged_mode, auto_charge_disable_strap,
        sideband_interface_select});
      chk("addr_bits", {r.strap[2] & ~r.strap[4], r.strap[0] & ~r.strap[4]},
        {slave_addr_bit_two_strap, slave_addr_bit_one_strap});
      chk("modes", r.modes, divider_charging_mode);
      port_power_request <= r.req;
      fault <= 4'h6;
      @(posedge clk);
      #1 chk("switch", r.sw, port_power_switch_out);
      repeat (2) @(posedge clk);
      #1 chk("overcurrent", r.strap[0] ? 4'h0 : (r.strap[2] ? 4'hf : 4'h6),
        overcurrent_event);
      chk("auto_port", (r.strap[0] | r.strap[2] | r.strap[3]) ? 4'h0 : 4'h9,
        auto_mode_port);
      @(posedge clk);
      fault <= 4'h0;
    end
    do_reset(5'h02);
    strap <= 5'h1d;
    repeat (3) @(posedge clk);
    rchk("held", `HSC_ADDR_STRAP, 32'h82);
    wr(`HSC_ADDR_CTRL, 32'h1);
    #1 chk("oe_on", 32'h3, {psw_pin_oe, gang_pin_oe});
    @(posedge clk);
    upstream_superspeed_linked <= 1'b1;
    upstream_connected <= 1'b1;
    @(posedge clk);
    #1 chk("status_ss", 32'ha0, {psw_pin_out, gang_pin_out, psw_pin_in, gang_pin_in,
      auto_mode_port});
    @(posedge clk);
    upstream_superspeed_linked <= 1'b0;
    upstream_highspeed_linked <= 1'b1;
    @(posedge clk);
    #1 chk("status_hs", 32'h5, {psw_pin_out, gang_pin_out, psw_pin_in, gang_pin_in});
    @(posedge clk);
    rchk("held_driven", `HSC_ADDR_STRAP, 32'h82);
    rchk("ctrl", `HSC_ADDR_CTRL, 32'h1);
    rchk("unmapped", 8'h08, 32'h0);
    wr(`HSC_ADDR_STRAP, 32'hffffffff);
    @(posedge clk);
    wr(`HSC_ADDR_CTRL, 32'h0);
    #1 chk("oe_off", 32'h0, {psw_pin_oe, gang_pin_oe});
    @(posedge clk);
    rchk("read_only", `HSC_ADDR_STRAP, 32'h82);
    summarize;
  end

  initial begin
    repeat (2000) @(posedge clk);
    mismatches++;
    summarize;
  end
endmodule : tb_top
